// [rtcsr_pkg.sv]
// Package of constants and carrier types for the supply/reset/timebase block
package rtcsr_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 40000000;  // System clock rate
  localparam int unsigned POWER_RECOVERY_HOLD_TIME_MS        = 250;       // Recovery hold, ms
  localparam int unsigned POWER_RECOVERY_HOLD_TIME_CYC       = POWER_RECOVERY_HOLD_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned START_CORR_S   = 2;         // First correction, s
  localparam int unsigned BAT_CORR_S     = 10;        // Backup cadence, s
  localparam int unsigned PUSHBUTTON_DEBOUNCE_TIME_CYC       = 1000;      // Debounce, cycles
  localparam int unsigned TRST_CYC       = 1000;      // Pulse time, cycles
  localparam int unsigned TICK_CYC       = CLK_HZ;    // Cycles per 1Hz tick

  // ----------------------------------------------------------------------
  // Register offsets (plain port)
  // ----------------------------------------------------------------------
  localparam logic [4:0] A_SEC   = 5'h00;  // Seconds
  localparam logic [4:0] A_MIN   = 5'h01;  // Minutes
  localparam logic [4:0] A_HOUR  = 5'h02;  // Hours
  localparam logic [4:0] A_DOW   = 5'h03;  // Weekday
  localparam logic [4:0] A_DATE  = 5'h04;  // Date
  localparam logic [4:0] A_MON   = 5'h05;  // Month/century
  localparam logic [4:0] A_YEAR  = 5'h06;  // Year
  localparam logic [4:0] A_CTRL  = 5'h0E;  // Control
  localparam logic [4:0] A_STAT  = 5'h0F;  // Status
  localparam logic [4:0] A_AGING = 5'h10;  // Aging offset
  localparam logic [4:0] A_TRIM  = 5'h13;  // Applied correction (read)

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned B_OSC_STOP = 7;  // Control: oscillator stop bit
  localparam int unsigned B_IRQ_SEL  = 2;  // Control: irq or square select
  localparam int unsigned B_H12      = 6;  // Hours: 12-hour mode
  localparam int unsigned B_PM       = 5;  // Hours: PM flag
  localparam logic [7:0] CTRL_RST    = 8'h04;  // Select bit set at power-up
  localparam logic [7:0] DAY1_BCD    = 8'h01;  // Preset day, month, weekday
  localparam logic [7:0] ZERO_BCD    = 8'h00;  // Preset time and year

  // Calendar carrier
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] dow;
    logic [7:0] date;
    logic [7:0] mon;
    logic [7:0] year;
  } rtcsr_cal_t;

  // Power states of the supply selector
  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_PRI = 2'b01,
    PWR_BAT = 2'b10
  } rtcsr_pwr_t;

  // Reset pin sequencer states
  typedef enum logic [2:0] {
    RS_IDLE = 3'b000,
    RS_PF   = 3'b001,
    RS_REC  = 3'b010,
    RS_DB   = 3'b011,
    RS_WREL = 3'b100,
    RS_PULS = 3'b101
  } rtcsr_rst_t;

endpackage : rtcsr_pkg

// [rtcsr_top.sv]
// Supply selection, reset pin, time base correction and BCD calendar
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
// How it works
// RL1: Above power-fail threshold run from primary
// RL2: Below threshold, backup only if primary lowest
// RL3: Primary below threshold drives reset low
// RL4: Correct every second primary, 10s backup
// RL5: Aging offset added to factory trim
// RL6: Backup alone: reset output off, low
// RL7: First battery: oscillator waits for primary/address
// RL8: Correction about 2s after start event
// RL9: Oscillator keeps running while any supply
// RL10: First start presets 01/01/00 01 00:00:00
// RL11: Stop bit halts oscillator, time frozen
// RL12: Idle: falling edge gives debounce low
// RL13: Still low: wait release, then pulse
// RL14: Primary return holds reset 250ms
// RL15: Oscillator stopped: skip hold, release now
// RL16: Reset pin never disturbs timekeeping
// RL17: Reset and pushbutton only on primary
// RL18: Calendar counts with month ends, leap years
// RL19: 12-hour or 24-hour hours selectable
// RL20: Output carries alarm irq or 1Hz square
// RL21: Register port answers on either supply
// RL22: Select 0 square, 1 irq; reset 1
// RL23: Time values held as BCD
// RL24: Debounce and pulse times are parameters
module rtcsr_top
  import rtcsr_pkg::*;
#(
  parameter int unsigned POWER_RECOVERY_HOLD_TIME_COUNT = POWER_RECOVERY_HOLD_TIME_CYC,   // Recovery hold cycles
  parameter int unsigned TICK_COUNT = TICK_CYC,   // Cycles per 1Hz tick
  parameter int unsigned PUSHBUTTON_DEBOUNCE_TIME_COUNT = PUSHBUTTON_DEBOUNCE_TIME_CYC,   // Debounce cycles
  parameter int unsigned TRST_COUNT = TRST_CYC    // Reset pulse cycles
) (
  input  wire logic       sys_clk,       // 40 MHz clock
  input  wire logic       nrst,          // Synchronous reset, active low
  input  wire logic       pri_above_pf,  // Primary above power-fail level
  input  wire logic       pri_above_bat, // Primary above backup level
  input  wire logic       bat_valid,     // Backup supply valid
  input  wire logic       bus_addr_hit,  // Valid bus address seen (pulse)
  input  wire logic       alarm_irq_n,   // Alarm interrupt, active low
  input  wire logic       rst_pin_in,    // Reset pin level
  output logic            rst_pin_out,   // Reset pin drive value
  output logic            rst_pin_oe,    // Reset pin drive enable
  output logic            on_backup,     // Running from backup supply
  output logic            alarm_irq_square_out, // Shared output level
  output logic            temp_meas,     // Correction pulse
  output logic signed [8:0] trim_applied, // Trim plus aging
  input  wire logic [4:0] reg_addr,      // Register address
  input  wire logic [7:0] reg_wdata,     // Write data
  input  wire logic       reg_wr,        // Write strobe
  input  wire logic       reg_rd,        // Read strobe
  output logic [7:0]      reg_rdata,     // Read data, cycle after strobe
  input  wire logic signed [7:0] factory_trim // Factory trim value
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (TICK_COUNT < 4 || PUSHBUTTON_DEBOUNCE_TIME_COUNT < 1 || TRST_COUNT < 1 || POWER_RECOVERY_HOLD_TIME_COUNT < 1)
    $error("rtcsr_top: counts too small");

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [4:0] sy1_reg;  // First stage, read only by second
  logic [4:0] sy2_reg;  // Second stage
  always_ff @(posedge sys_clk) begin
    sy1_reg <= {rst_pin_in, pri_above_pf, pri_above_bat, bat_valid,
                alarm_irq_n};
    sy2_reg <= sy1_reg;
  end
  logic pin_s, pf_ok, pri_hi, bat_ok, irq_n_s;
  assign {pin_s, pf_ok, pri_hi, bat_ok, irq_n_s} = sy2_reg;

  // ----------------------------------------------------------------------
  // Supply selection
  // ----------------------------------------------------------------------
  rtcsr_pwr_t pwr_next;  // Selected source
  always_comb begin
    if (pf_ok)
      pwr_next = PWR_PRI;  // RL1
    else if (pri_hi)
      pwr_next = PWR_PRI;  // RL2
    else if (bat_ok)
      pwr_next = PWR_BAT;  // RL2
    else
      pwr_next = PWR_OFF;
  end
  rtcsr_pwr_t pwr_reg;
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      pwr_reg <= PWR_OFF;
    else
      pwr_reg <= pwr_next;
  end
  assign on_backup = (pwr_reg == PWR_BAT);
  // Logic alive only on a valid supply; the port is served then
  logic powered;
  assign powered = (pwr_reg != PWR_OFF);  // RL21

  // ----------------------------------------------------------------------
  // Oscillator start gating and control register
  // ----------------------------------------------------------------------
  logic [7:0] ctrl_reg;     // Control register
  logic       started_reg;  // Oscillator released once
  logic       preset_reg;   // Calendar preset done
  logic       osc_run;
  logic       start_evt;
  assign start_evt = pf_ok || (bus_addr_hit && powered);
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      started_reg <= 1'b0;
    else if (start_evt)
      started_reg <= 1'b1;  // RL7
  end
  // Stop bit halts; otherwise runs on any supply once released
  assign osc_run = started_reg && powered && !ctrl_reg[B_OSC_STOP]; // RL9 RL11

  // ----------------------------------------------------------------------
  // 1Hz tick divider
  // ----------------------------------------------------------------------
  logic [31:0] div_reg;
  logic        tick;
  logic        sq_reg;  // 1Hz square, high half first
  assign tick = osc_run && (div_reg == 32'(TICK_COUNT - 1));
  logic sec_wr;
  assign sec_wr = reg_wr && (reg_addr == A_SEC);
  always_ff @(posedge sys_clk) begin
    if (!nrst || !osc_run || sec_wr)
      div_reg <= 32'h0;  // Writing seconds restarts the chain
    else if (tick)
      div_reg <= 32'h0;
    else
      div_reg <= div_reg + 32'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      sq_reg <= 1'b1;
    else
      sq_reg <= (div_reg < 32'(TICK_COUNT / 2));
  end

  // ----------------------------------------------------------------------
  // Correction cadence
  // ----------------------------------------------------------------------
  logic [3:0] corr_reg;  // Seconds since last correction
  logic       first_reg; // First correction still pending
  logic       corr_due;
  always_comb begin
    if (first_reg)
      corr_due = (corr_reg >= 4'(START_CORR_S - 1));  // RL8
    else if (on_backup)
      corr_due = (corr_reg >= 4'(BAT_CORR_S - 1));    // RL4
    else
      corr_due = 1'b1;                                // RL4
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst || !osc_run) begin
      corr_reg  <= 4'h0;
      first_reg <= 1'b1;
      temp_meas <= 1'b0;
    end else begin
      temp_meas <= tick && corr_due;
      if (tick) begin
        corr_reg <= corr_due ? 4'h0 : corr_reg + 4'h1;
        if (corr_due)
          first_reg <= 1'b0;
      end
    end
  end

  // Aging offset joins the factory trim on each correction
  logic [7:0] aging_reg;
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      trim_applied <= 9'sh000;
    else if (temp_meas)
      trim_applied <= 9'(factory_trim) + 9'($signed(aging_reg));  // RL5
  end

  // ----------------------------------------------------------------------
  // BCD calendar helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};  // RL23
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic [7:0] month_end(input logic [4:0] m,
                                           input logic [7:0] y);
    logic leap;
    leap = (y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                 : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8));
    case (m)
      5'h02:                      month_end = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_end = 8'h30;
      default:                    month_end = 8'h31;
    endcase
  endfunction : month_end

  // ----------------------------------------------------------------------
  // Calendar counting, presets and software writes
  // ----------------------------------------------------------------------
  rtcsr_cal_t cal_reg;
  rtcsr_cal_t cal_next;
  logic       h12;
  assign h12 = cal_reg.hour[B_H12];
  always_comb begin
    cal_next = cal_reg;
    if (cal_reg.sec != 8'h59) cal_next.sec = bcd_inc(cal_reg.sec);  // RL18
    else begin
      cal_next.sec = ZERO_BCD;
      if (cal_reg.min != 8'h59) cal_next.min = bcd_inc(cal_reg.min);
      else begin
        cal_next.min = ZERO_BCD;
        if (h12) begin  // RL19
          if (cal_reg.hour[4:0] == 5'h11)
            cal_next.hour = {2'b01, ~cal_reg.hour[B_PM], 5'h12};
          else if (cal_reg.hour[4:0] == 5'h12)
            cal_next.hour = {3'b010 | {2'b00, cal_reg.hour[B_PM]}, 5'h01};
          else
            cal_next.hour = {cal_reg.hour[7:5], 5'(bcd_inc(
                             {3'b000, cal_reg.hour[4:0]}))};
        end else if (cal_reg.hour[5:0] != 6'h23)
          cal_next.hour = {2'b00, 6'(bcd_inc({2'b00, cal_reg.hour[5:0]}))};
        else
          cal_next.hour = ZERO_BCD;
        // Midnight rolls the day in either mode
        if ((h12 && cal_reg.hour[B_PM] && cal_reg.hour[4:0] == 5'h11) ||
            (!h12 && cal_reg.hour[5:0] == 6'h23)) begin
          cal_next.dow = (cal_reg.dow == 8'h07) ? DAY1_BCD
                                                : bcd_inc(cal_reg.dow);
          if (cal_reg.date != month_end(cal_reg.mon[4:0], cal_reg.year))
            cal_next.date = bcd_inc(cal_reg.date);
          else begin
            cal_next.date = DAY1_BCD;
            if (cal_reg.mon[4:0] != 5'h12)
              cal_next.mon = {cal_reg.mon[7], 2'b00,
                              5'(bcd_inc({3'b000, cal_reg.mon[4:0]}))};
            else begin
              // Rollover from year 99 to 00 toggles the century flag
              cal_next.mon  = {cal_reg.year == 8'h99 ? ~cal_reg.mon[7]
                                                     : cal_reg.mon[7], 7'h01};
              cal_next.year = (cal_reg.year == 8'h99) ? ZERO_BCD
                                                      : bcd_inc(cal_reg.year);
            end
          end
        end
      end
    end
  end

  // Preset on first primary or first address on battery
  logic do_preset;
  assign do_preset = !preset_reg && start_evt;  // RL10
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      preset_reg <= 1'b0;
    else if (do_preset)
      preset_reg <= 1'b1;
  end
  // Reset pin activity never reaches this process
  always_ff @(posedge sys_clk) begin  // RL16
    if (!nrst || do_preset)
      cal_reg <= '{sec: ZERO_BCD, min: ZERO_BCD, hour: ZERO_BCD,
                   dow: DAY1_BCD, date: DAY1_BCD, mon: DAY1_BCD,
                   year: ZERO_BCD};  // RL10
    else if (reg_wr && powered) begin
      case (reg_addr)
        A_SEC:   cal_reg.sec  <= reg_wdata;
        A_MIN:   cal_reg.min  <= reg_wdata;
        A_HOUR:  cal_reg.hour <= reg_wdata;
        A_DOW:   cal_reg.dow  <= reg_wdata;
        A_DATE:  cal_reg.date <= reg_wdata;
        A_MON:   cal_reg.mon  <= reg_wdata;
        A_YEAR:  cal_reg.year <= reg_wdata;
        default: ;
      endcase
    end else if (tick)
      cal_reg <= cal_next;  // RL18
  end

  // ----------------------------------------------------------------------
  // Control and aging registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_reg  <= CTRL_RST;  // RL22
      aging_reg <= 8'h00;
    end else if (reg_wr && powered) begin
      if (reg_addr == A_CTRL)  ctrl_reg  <= reg_wdata;
      if (reg_addr == A_AGING) aging_reg <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Shared alarm/square output
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      alarm_irq_square_out <= 1'b1;
    else if (ctrl_reg[B_IRQ_SEL])
      alarm_irq_square_out <= irq_n_s;       // RL20 RL22
    else
      alarm_irq_square_out <= sq_reg || !osc_run;  // RL20 RL22
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd && powered) begin  // RL21
      case (reg_addr)
        A_SEC:   reg_rdata <= cal_reg.sec;
        A_MIN:   reg_rdata <= cal_reg.min;
        A_HOUR:  reg_rdata <= cal_reg.hour;
        A_DOW:   reg_rdata <= cal_reg.dow;
        A_DATE:  reg_rdata <= cal_reg.date;
        A_MON:   reg_rdata <= cal_reg.mon;
        A_YEAR:  reg_rdata <= cal_reg.year;
        A_CTRL:  reg_rdata <= ctrl_reg;
        A_STAT:  reg_rdata <= {!started_reg, 6'h00, on_backup};
        A_AGING: reg_rdata <= aging_reg;
        A_TRIM:  reg_rdata <= trim_applied[7:0];
        default: reg_rdata <= 8'h00;  // Unmapped reads zero
      endcase
    end else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------------------------------------
  // Reset pin sequencer
  // ----------------------------------------------------------------------
  rtcsr_rst_t rs_reg;
  logic [31:0] rcnt_reg;  // Phase timer
  logic        pin_d_reg; // Last synced pin level
  logic        pri_on;
  assign pri_on = (pwr_reg == PWR_PRI);
  always_ff @(posedge sys_clk) begin
    if (!nrst)
      pin_d_reg <= 1'b1;
    else
      pin_d_reg <= pin_s;
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rs_reg   <= RS_PF;
      rcnt_reg <= 32'h0;
    end else if (!pf_ok) begin
      rs_reg   <= RS_PF;  // RL3
      rcnt_reg <= 32'h0;
    end else begin
      rcnt_reg <= rcnt_reg + 32'h1;
      case (rs_reg)
        RS_PF: begin
          rcnt_reg <= 32'h0;
          rs_reg   <= osc_run ? RS_REC : RS_IDLE;  // RL14 RL15
        end
        RS_REC:
          if (rcnt_reg == 32'(POWER_RECOVERY_HOLD_TIME_COUNT - 1)) rs_reg <= RS_IDLE;  // RL14
        RS_IDLE: begin
          rcnt_reg <= 32'h0;
          if (pin_d_reg && !pin_s) rs_reg <= RS_DB;  // RL12
        end
        RS_DB:
          if (rcnt_reg == 32'(PUSHBUTTON_DEBOUNCE_TIME_COUNT - 1)) begin  // RL24
            rcnt_reg <= 32'h0;
            rs_reg   <= RS_WREL;  // RL13
          end
        RS_WREL: begin
          rcnt_reg <= 32'h0;
          if (pin_s) rs_reg <= RS_PULS;  // RL13
        end
        RS_PULS:
          if (rcnt_reg == 32'(TRST_COUNT - 1)) rs_reg <= RS_IDLE;  // RL24
        default: rs_reg <= RS_PF;
      endcase
    end
  end
  // Open-drain drive; nothing driven without primary supply
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe  = pri_on && (rs_reg == RS_PF || rs_reg == RS_REC ||
                       rs_reg == RS_DB || rs_reg == RS_PULS);  // RL6 RL17

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  prim_sel_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pf_ok |=> pwr_reg == PWR_PRI) else $error("not on primary"); // RL1
  bat_sel_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!pf_ok && !pri_hi && bat_ok) |=> on_backup)
    else $error("backup not chosen"); // RL2
  pf_drive_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!pf_ok && pwr_reg == PWR_PRI) ##1 pwr_reg == PWR_PRI |-> rst_pin_oe)
    else $error("reset not low on fail"); // RL3
  bat_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    on_backup |-> !rst_pin_oe) else $error("reset driven on backup"); // RL6
  osc_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !started_reg |-> !tick) else $error("tick before start"); // RL7
  stop_bit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ctrl_reg[B_OSC_STOP] |=> $stable(cal_reg) || $past(reg_wr))
    else $error("time moved while stopped"); // RL11
  sel_reset_a: assert property (@(posedge sys_clk)
    !nrst |=> ctrl_reg[B_IRQ_SEL]) else $error("select not 1"); // RL22
  db_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rs_reg == RS_IDLE && pin_d_reg && !pin_s && pf_ok && pri_on)
    |=> rst_pin_oe [*1] ##0 rs_reg == RS_DB)
    else $error("no debounce drive"); // RL12
  no_rec_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (rs_reg == RS_PF && pf_ok && !osc_run) |=> rs_reg == RS_IDLE)
    else $error("hold not skipped"); // RL15
  corr_cad_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    temp_meas |-> $past(tick)) else $error("correction off tick"); // RL4

endmodule : rtcsr_top

// [rtcsr_pin_model.sv]
// Reset pin wire: internal pull-up on the primary rail plus a pushbutton
`timescale 1ns/1ps
module rtcsr_pin_model (
  input  wire logic pri_on,  // Primary rail present
  input  wire logic oe,      // Device pulls the pin low
  input  wire logic btn,     // Pushbutton pressed
  output logic      pin      // Resolved pin level
);
  // -----------------------------------------------------------------
  // Open-drain resolution
  // -----------------------------------------------------------------
  // Pull-up hangs off the primary rail, so on backup the pin reads low
  assign pin = pri_on & ~oe & ~btn;
endmodule : rtcsr_pin_model

// [tb.sv]
// Self-checking bench for supply, reset pin, time base and calendar
`timescale 1ns/1ps
module tb;
  import rtcsr_pkg::*;
  // -----------------------------------------------------------------
  // Signals
  // -----------------------------------------------------------------
  logic sys_clk, nrst, pf, pab, bat, irq_n, btn, pin, oe, on_bak, tm, sq;
  logic reg_wr, reg_rd;
  logic hit, pout;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, rdata;
  logic signed [8:0] trim;
  int failures, total_checks;
  rtcsr_top #(.POWER_RECOVERY_HOLD_TIME_COUNT(20), .TICK_COUNT(40), .PUSHBUTTON_DEBOUNCE_TIME_COUNT(5),
              .TRST_COUNT(5)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .pri_above_pf(pf),
    .pri_above_bat(pab), .bat_valid(bat), .bus_addr_hit(hit),
    .alarm_irq_n(irq_n), .rst_pin_in(pin), .rst_pin_out(pout),
    .rst_pin_oe(oe), .on_backup(on_bak), .alarm_irq_square_out(sq),
    .temp_meas(tm), .trim_applied(trim), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .factory_trim(8'shFD));
  rtcsr_pin_model pin_u (.pri_on(pf | pab), .oe(oe), .btn(btn),
                         .pin(pin));
  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic check(input logic [8:0] s, input logic [8:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic end_sim;
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  function automatic logic sig(input logic [1:0] s);
    return s == 2'd0 ? oe : (s == 2'd1 ? tm : sq);
  endfunction : sig
  // Cycles in which the chosen output is high over a window
  task automatic count(input logic [1:0] s, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1 c += (sig(s) === 1'b1);
    end
  endtask : count
  // Bounded wait for a level; a hang ends the run as a failure
  task automatic wait_for(input logic [1:0] s, input logic v,
                          output int n);
    n = 0;
    while (sig(s) !== v) begin
      @(posedge sys_clk);
      #1 n++;
      if (n > 2000) begin
        failures++;
        end_sim();
      end
    end
  endtask : wait_for
  task automatic in_range(input int n, input int lo, input int hi);
    check(9'(n >= lo && n <= hi), 9'h001);
  endtask : in_range
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr_reg
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic set_pwr(input logic p, input logic b);
    @(posedge sys_clk);
    pf  <= p;
    pab <= b;
    cyc(4);
  endtask : set_pwr
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic s_cold_battery;
    logic [7:0] d;
    check(9'(on_bak), 9'h001);
    check(9'(oe), 9'h000);
    rd_reg(A_STAT, d);
    check(9'(d[7]), 9'h001);
    cyc(100);
    rd_reg(A_SEC, d);
    check(9'(d), 9'h000);
  endtask : s_cold_battery
  task automatic s_first_primary;
    logic [7:0] ex [6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    logic [7:0] d;
    int n, m;
    @(posedge sys_clk);
    pf  <= 1'b1;
    pab <= 1'b1;
    count(2'd0, 30, n);
    check(9'(n), 9'h000);
    check(9'(on_bak), 9'h000);
    wait_for(2'd1, 1'b1, m);
    in_range(30 + m, 80, 86);
    for (int i = 1; i < 7; i++) begin
      rd_reg(5'(i), d);
      check(9'(d), 9'(ex[i-1]));
    end
  endtask : s_first_primary
  task automatic s_power_fail;
    int n;
    set_pwr(1'b0, 1'b1);
    check(9'(on_bak), 9'h000);
    check(9'(oe), 9'h001);
    check(9'(pout), 9'h000);
    set_pwr(1'b1, 1'b1);
    wait_for(2'd0, 1'b0, n);
    in_range(n + 4, 20, 26);
  endtask : s_power_fail
  task automatic s_cadence;
    logic [7:0] d;
    int n;
    wr_reg(A_AGING, 8'h05);
    count(2'd1, 400, n);
    in_range(n, 9, 11);
    check(trim, 9'h002);
    set_pwr(1'b0, 1'b0);
    check(9'(oe), 9'h000);
    check(9'(on_bak), 9'h001);
    rd_reg(A_CTRL, d);
    check(9'(d), 9'h004);
    count(2'd1, 1600, n);
    in_range(n, 3, 5);
    set_pwr(1'b1, 1'b1);
    cyc(40);
  endtask : s_cadence
  task automatic s_button;
    int n;
    @(posedge sys_clk);
    btn <= 1'b1;
    wait_for(2'd0, 1'b1, n);
    in_range(n, 1, 5);
    wait_for(2'd0, 1'b0, n);
    in_range(n, 4, 6);
    count(2'd0, 10, n);
    check(9'(n), 9'h000);
    @(posedge sys_clk);
    btn <= 1'b0;
    wait_for(2'd0, 1'b1, n);
    in_range(n, 1, 5);
    wait_for(2'd0, 1'b0, n);
    in_range(n, 4, 6);
  endtask : s_button
  // Midnight rollover in 24-hour mode on leap-year Feb 28 and in 12-hour mode at a month end
  task automatic s_calendar;
    logic [7:0] hr [2] = '{8'h23, 8'h71};
    logic [7:0] hx [2] = '{8'h00, 8'h52};
    logic [7:0] dt [2] = '{8'h28, 8'h30};
    logic [7:0] mo [2] = '{8'h02, 8'h04};
    logic [7:0] dx [2] = '{8'h29, 8'h01};
    logic [7:0] d;
    for (int i = 0; i < 2; i++) begin
      // Restart the chain first so no tick lands among the writes
      wr_reg(A_SEC, 8'h00);
      wr_reg(A_MIN, 8'h59);
      wr_reg(A_HOUR, hr[i]);
      wr_reg(A_DATE, dt[i]);
      wr_reg(A_MON, mo[i]);
      wr_reg(A_YEAR, 8'h04);
      wr_reg(A_SEC, 8'h59);
      cyc(45);
      rd_reg(A_HOUR, d);
      check(9'(d), 9'(hx[i]));
      rd_reg(A_DATE, d);
      check(9'(d), 9'(dx[i]));
    end
  endtask : s_calendar
  task automatic s_stop_and_output;
    logic [7:0] a, b;
    int n;
    wr_reg(A_CTRL, 8'h84);
    rd_reg(A_SEC, a);
    cyc(200);
    rd_reg(A_SEC, b);
    check(9'(b), 9'(a));
    wr_reg(A_CTRL, 8'h00);
    count(2'd2, 80, n);
    in_range(n, 35, 45);
    wr_reg(A_CTRL, 8'h04);
    irq_n <= 1'b0;
    cyc(4);
    count(2'd2, 80, n);
    check(9'(n), 9'h000);
  endtask : s_stop_and_output
  // Battery-only restart, oscillator released by a bus address
  task automatic s_addr_start;
    logic [7:0] d;
    int n;
    set_pwr(1'b0, 1'b0);
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    cyc(2);
    rd_reg(A_STAT, d);
    check(9'(d), 9'h081);
    @(posedge sys_clk);
    hit <= 1'b1;
    @(posedge sys_clk);
    hit <= 1'b0;
    wait_for(2'd1, 1'b1, n);
    in_range(n, 78, 82);
    rd_reg(A_STAT, d);
    check(9'(d), 9'h001);
  endtask : s_addr_start
  // -----------------------------------------------------------------
  // Clock and main sequence
  // -----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    {nrst, pf, pab, btn, reg_wr, reg_rd, hit} = '0;
    {bat, irq_n} = 2'b11;
    reg_addr  = '0;
    reg_wdata = '0;
    cyc(6);
    nrst <= 1'b1;
    cyc(4);
    s_cold_battery();
    s_first_primary();
    s_power_fail();
    s_cadence();
    s_button();
    s_calendar();
    s_stop_and_output();
    s_addr_start();
    end_sim();
  end
endmodule : tb
